// ### sarh_pkg.sv
// Shared constants for the attention and bus reset handler.
// Assumes a 200 MHz ref_clk; bus delays are counted in clock cycles.
package sarh_pkg;
  // Timing in nanoseconds and derived clock counts (5 ns period)
  localparam int CLK_PERIOD_NS = 5;
  localparam int DESKEW_NS = 45;
  localparam int ATN_SETUP_NS = 90;
  localparam int RST_HOLD_NS = 25000;
  localparam int RST_DELAY_NS = 200;
  localparam int BUS_CLEAR_NS = 800;
  localparam int DESKEW_CYC = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ATN_SETUP_CYC = (ATN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_DELAY_CYC = (RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_CLEAR_CYC = BUS_CLEAR_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // Bus phase codes, driven by the target on the phase lines
  typedef enum logic [2:0] {
    SARH_PH_FREE,
    SARH_PH_SELECT,
    SARH_PH_RESELECT,
    SARH_PH_COMMAND,
    SARH_PH_DATA,
    SARH_PH_STATUS,
    SARH_PH_MSG_IN,
    SARH_PH_MSG_OUT
  } sarh_phase_t;

  // Unit attention codes (additional sense meaning)
  localparam logic [2:0] UA_NONE = 3'h0;
  localparam logic [2:0] UA_BUS_RESET = 3'h1;
  localparam logic [2:0] UA_POWER_ON = 3'h2;
  localparam logic [2:0] UA_TARGET_RESET = 3'h3;
  localparam logic [2:0] UA_MODE_SE = 3'h4;
  localparam logic [2:0] UA_MODE_LVD = 3'h5;
endpackage

// ### sarh_bus_if.sv
// Bus wires between initiator and target ends.
// Assumes the testbench supplies ref_clk; RST is wired-OR of both enables.
`timescale 1ns/100ps
`default_nettype none
interface sarh_bus_if (
  input wire logic ref_clk // Common clock
);
  logic atn;                   // Attention, from initiator
  logic ack;                   // Acknowledge, from initiator
  logic bsy_i;                 // Initiator drives busy
  logic sel_id;                // Initiator puts target id on bus
  logic req;                   // Request, from target
  sarh_pkg::sarh_phase_t phase; // Bus phase, from target
  logic last_unit;             // Target: end of IU / data boundary
  logic rst_oe_i;              // Initiator drives RST
  logic rst_oe_t;              // Target drives RST
  logic rst;
  assign rst = rst_oe_i | rst_oe_t;

  modport init (output atn, ack, bsy_i, sel_id, rst_oe_i,
                input req, phase, last_unit, rst);
  modport targ (input atn, ack, bsy_i, sel_id, rst_oe_i,
                output req, phase, last_unit, rst_oe_t, input rst);
endinterface
`default_nettype wire

// ### sarh_target.sv
// Target end: attention response, RST filter, hard reset, unit attention.
// Assumes bus inputs synchronous to ref_clk; user side steps phases.
// Contract
// - Target answers valid attention with MESSAGE OUT
// - Initiator: ATN two deskews before BSY release
// - Initiator: ATN two deskews before QAS id
// - Initiator: ATN setup before ACK negation
// - Initiator: retry ATN two deskews before ACK
// - Initiator: clear ATN two deskews before ACK
// - Initiator never drops ATN while ACK in MSGOUT
// - Attention by last transfer of phase/unit
// - Initiator holds ATN until MESSAGE OUT
// - ATN off on last byte, else BUS FREE
// - COMMAND: MESSAGE OUT after some CDB bytes
// - DATA: MESSAGE OUT at convenient boundary
// - STATUS: MESSAGE OUT after status acknowledged
// - MESSAGE IN: MESSAGE OUT before next message
// - SELECTION: MESSAGE OUT right after selection
// - RESELECTION: after IDENTIFY or first phase
// - Data stream: MESSAGE OUT at unit end
// - RST held forces BUS FREE over all
// - Ignore RST shorter than reset delay; code filters only the reset event, any RST still releases the bus at once
// - Release signals within bus clear delay
// - Never echo RST; restore default agreement
// - Post unit attention naming the event
`timescale 1ns/100ps
`default_nettype none
module sarh_target #(
  parameter int RST_DELAY = sarh_pkg::RST_DELAY_CYC,
  parameter int BUS_CLEAR = sarh_pkg::BUS_CLEAR_CYC
) (
  input wire logic ref_clk,            // Clock
  input wire logic srst,               // Sync reset, active high
  sarh_bus_if.targ bus,                // Bus side
  input wire logic iu_enabled,         // Information unit transfers on
  input wire logic usr_step,           // Pulse: current phase/unit done
  input wire sarh_pkg::sarh_phase_t usr_phase, // Next phase wanted by user
  input wire logic usr_boundary,       // Convenient break point now
  input wire logic usr_last_byte,      // MSGOUT byte ends a flagged message
  input wire logic usr_target_reset,   // Pulse: target reset message taken
  input wire logic usr_assert_rst,     // Request to drive RST
  input wire logic lvd_mode,           // Transceiver mode, 1 = LVD
  input wire logic ua_clear,           // Pulse: unit attention reported
  output logic attn_pending,           // Attention latched
  output logic bus_released,           // Bus signals released by reset
  output logic hard_reset,             // Pulse: reset event
  output logic default_agreement,      // Pulse: restore default transfer
  output logic [2:0] ua_code,          // Pending unit attention code
  output logic msg_protocol_err        // Pulse: ATN on last byte
);
  localparam int CW = sarh_pkg::CNT_W;

  sarh_pkg::sarh_phase_t phase;
  logic req;
  logic last_unit;
  logic rst_oe;
  logic [CW-1:0] rst_cnt;
  logic rst_seen;
  logic lvd_q;
  logic por;
  logic first_done;

  ////////////////////////////////////////////////////////////////////////
  // Reset filter and event detection
  wire logic rst_ext = bus.rst & ~rst_oe;
  wire logic rst_qualified = rst_ext && (rst_cnt >= CW'(RST_DELAY - 1));
  wire logic rst_event = rst_qualified & ~rst_seen;
  wire logic mode_change = (lvd_q != lvd_mode) & ~por;
  wire logic any_reset = rst_event | mode_change | usr_target_reset | por;
  // Release follows the raw RST level so the clear delay is honoured
  wire logic release_now = rst_ext | rst_seen;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_cnt <= '0;
      rst_seen <= 1'b0;
    end else begin
      rst_cnt <= rst_ext ? ((rst_cnt == '1) ? rst_cnt : rst_cnt + CW'(1)) : '0;
      rst_seen <= rst_ext ? (rst_seen | rst_qualified) : 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lvd_q <= 1'b1;
      por <= 1'b1;
    end else begin
      lvd_q <= lvd_mode;
      por <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unit attention: a new event wins over a clear
  function automatic logic [2:0] ua_of(input logic pw, input logic br,
                                       input logic tr, input logic mc,
                                       input logic lvd);
    if (pw) ua_of = sarh_pkg::UA_POWER_ON;
    else if (br) ua_of = sarh_pkg::UA_BUS_RESET;
    else if (mc) ua_of = lvd ? sarh_pkg::UA_MODE_LVD : sarh_pkg::UA_MODE_SE;
    else if (tr) ua_of = sarh_pkg::UA_TARGET_RESET;
    else ua_of = sarh_pkg::UA_NONE;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ua_code <= sarh_pkg::UA_NONE;
      hard_reset <= 1'b0;
      default_agreement <= 1'b0;
      bus_released <= 1'b0;
    end else begin
      if (any_reset)
        ua_code <= ua_of(por, rst_event, usr_target_reset, mode_change, lvd_mode);
      else if (ua_clear)
        ua_code <= sarh_pkg::UA_NONE;
      hard_reset <= any_reset;
      default_agreement <= any_reset;
      bus_released <= release_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Attention response and phase control
  wire logic atn_now = bus.atn & ~release_now;
  wire logic in_msgout = (phase == sarh_pkg::SARH_PH_MSG_OUT);
  // Point at which the current phase may yield to MESSAGE OUT
  wire logic yield_ok =
      (phase == sarh_pkg::SARH_PH_SELECT) ? usr_step :
      (phase == sarh_pkg::SARH_PH_RESELECT) ? 1'b0 :
      (phase == sarh_pkg::SARH_PH_COMMAND) ? usr_step | usr_boundary :
      (phase == sarh_pkg::SARH_PH_DATA) ?
          (iu_enabled ? usr_step : usr_boundary | usr_step) :
      (phase == sarh_pkg::SARH_PH_STATUS) ? usr_step :
      (phase == sarh_pkg::SARH_PH_MSG_IN) ? usr_step :
      1'b0;
  // Reselection waits for IDENTIFY or first information phase
  wire logic resel_yield = first_done & usr_step;
  wire logic go_msgout = attn_pending & ~in_msgout & (yield_ok | resel_yield);
  wire logic bad_last = in_msgout & usr_step & usr_last_byte & bus.atn;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      attn_pending <= 1'b0;
      first_done <= 1'b0;
      phase <= sarh_pkg::SARH_PH_FREE;
      req <= 1'b0;
      last_unit <= 1'b0;
      msg_protocol_err <= 1'b0;
    end else if (release_now) begin
      attn_pending <= 1'b0;
      first_done <= 1'b0;
      phase <= sarh_pkg::SARH_PH_FREE;
      req <= 1'b0;
      last_unit <= 1'b0;
      msg_protocol_err <= 1'b0;
    end else begin
      // Served on entry to MESSAGE OUT, even though ATN may still stand
      attn_pending <= ~in_msgout & ~go_msgout & (atn_now | attn_pending);
      msg_protocol_err <= bad_last;
      last_unit <= usr_boundary | usr_step;
      req <= (phase != sarh_pkg::SARH_PH_FREE) & ~usr_step;
      if (phase == sarh_pkg::SARH_PH_RESELECT && usr_step)
        first_done <= 1'b1;
      if (bad_last)
        phase <= sarh_pkg::SARH_PH_FREE;
      else if (go_msgout)
        phase <= sarh_pkg::SARH_PH_MSG_OUT;
      else if (usr_step && !(phase == sarh_pkg::SARH_PH_RESELECT && !iu_enabled && attn_pending))
        phase <= usr_phase;
      else if (usr_step)
        phase <= sarh_pkg::SARH_PH_MSG_IN; // IDENTIFY goes out first
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      rst_oe <= 1'b0;
    else
      rst_oe <= usr_assert_rst & ~rst_ext;
  end

  assign bus.phase = phase;
  assign bus.req = req;
  assign bus.last_unit = last_unit;
  assign bus.rst_oe_t = rst_oe;
endmodule
`default_nettype wire

// ### sarh_initiator.sv
// Initiator end: times ATN against BSY, id, ACK; drives RST.
// Assumes the target end drives phase and REQ through sarh_bus_if.
`timescale 1ns/100ps
`default_nettype none
module sarh_initiator #(
  parameter int DESKEW2 = 2 * sarh_pkg::DESKEW_CYC,    // Two deskew delays
  parameter int ATN_SETUP = sarh_pkg::ATN_SETUP_CYC,   // Attention setup
  parameter int RST_HOLD = sarh_pkg::RST_HOLD_CYC      // Reset hold time
) (
  input wire logic ref_clk,        // Clock
  input wire logic srst,           // Sync reset, active high
  sarh_bus_if.init bus,            // Bus side
  input wire logic usr_attn,       // Level: message ready to send
  input wire logic usr_more,       // More message bytes follow
  input wire logic usr_qas,        // Selection follows QAS
  input wire logic usr_select,     // Pulse: start selection
  input wire logic usr_reset,      // Pulse: create bus reset
  output logic busy,               // Selection or handshake in progress
  output logic atn_out,            // Copy of ATN driven
  output logic rst_active          // RST being driven
);
  localparam int CW = sarh_pkg::CNT_W;
  typedef enum logic [1:0] {SARH_I_IDLE, SARH_I_SEL, SARH_I_XFER} sarh_ist_t;

  sarh_ist_t st;
  logic [CW-1:0] cnt;
  logic [CW-1:0] rcnt;
  logic atn;
  logic ack;
  logic bsy;
  logic sel_id;
  logic rst_oe;

  ////////////////////////////////////////////////////////////////////////
  // ATN set first, then the bus action two deskews later
  wire logic in_msgout = (bus.phase == sarh_pkg::SARH_PH_MSG_OUT);
  wire logic bus_free = (bus.phase == sarh_pkg::SARH_PH_FREE);
  wire logic want_atn = usr_attn | (in_msgout & usr_more);
  // In MESSAGE OUT, ATN may only change while ACK is low
  wire logic next_atn = ack & in_msgout ? atn : want_atn;
  wire logic cnt_done = (cnt == '0);
  // Handshake edges wait out setup after any ATN change
  wire logic [CW-1:0] gap = CW'(DESKEW2 > ATN_SETUP ? DESKEW2 : ATN_SETUP);

  always_ff @(posedge ref_clk) begin
    if (srst || bus.rst) begin
      st <= SARH_I_IDLE;
      cnt <= '0;
      atn <= 1'b0;
      ack <= 1'b0;
      bsy <= 1'b0;
      sel_id <= 1'b0;
    end else begin
      atn <= next_atn;
      cnt <= (next_atn != atn) ? gap : (cnt_done ? cnt : cnt - CW'(1));
      case (st)
        SARH_I_IDLE: begin
          if (usr_select) begin
            st <= SARH_I_SEL;
            bsy <= ~usr_qas;
            cnt <= CW'(DESKEW2);
          end
        end
        SARH_I_SEL: begin
          if (cnt_done && next_atn == atn) begin
            bsy <= 1'b0;
            sel_id <= 1'b1;
            st <= SARH_I_XFER;
          end
        end
        SARH_I_XFER: begin
          // Keeps handshaking until the target goes to BUS FREE
          if (bus_free) begin
            st <= SARH_I_IDLE;
            sel_id <= 1'b0;
            ack <= 1'b0;
          end else if (bus.req && !ack && cnt_done && next_atn == atn)
            ack <= 1'b1;
          else if (!bus.req && ack && cnt_done)
            ack <= 1'b0;
        end
        default: st <= SARH_I_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus reset drive, held for the reset hold time
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rst_oe <= 1'b0;
      rcnt <= '0;
    end else if (usr_reset && !rst_oe) begin
      rst_oe <= 1'b1;
      rcnt <= CW'(RST_HOLD - 1);
    end else if (rst_oe) begin
      rcnt <= (rcnt == '0) ? rcnt : rcnt - CW'(1);
      rst_oe <= (rcnt != '0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy <= 1'b0;
      atn_out <= 1'b0;
      rst_active <= 1'b0;
    end else begin
      busy <= (st != SARH_I_IDLE);
      atn_out <= atn;
      rst_active <= rst_oe;
    end
  end

  assign bus.atn = atn;
  assign bus.ack = ack;
  assign bus.bsy_i = bsy;
  assign bus.sel_id = sel_id;
  assign bus.rst_oe_i = rst_oe;
endmodule
`default_nettype wire

// ### sarh_bus_properties.sv
// Concurrent checks on the bus joining the initiator and target ends.
// Assumes the testbench ties each input to the matching interface signal.
`timescale 1ns/100ps
`default_nettype none
module sarh_bus_properties #(
  parameter int DESKEW2 = 2 * sarh_pkg::DESKEW_CYC, // Two deskew delays
  parameter int ATN_SETUP = sarh_pkg::ATN_SETUP_CYC // Attention setup
) (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic atn, // Attention
  input wire logic ack, // Acknowledge
  input wire logic bsy_i, // Initiator busy
  input wire logic sel_id, // Target id on bus
  input wire logic req, // Request
  input wire sarh_pkg::sarh_phase_t phase, // Bus phase
  input wire logic rst_oe_i, // Initiator drives RST
  input wire logic rst_oe_t, // Target drives RST
  input wire logic rst // Wired RST
);
  localparam int CLEAR_MAX = sarh_pkg::BUS_CLEAR_CYC;
  logic atn_q;
  logic atn_served;
  logic [7:0] atn_age;
  wire logic msg_out;
  assign msg_out = (phase == sarh_pkg::SARH_PH_MSG_OUT);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // Age of the current ATN level; saturates so long idle stays legal
  always_ff @(posedge ref_clk) begin
    atn_q <= atn;
    if (srst || atn != atn_q) atn_age <= 8'h00;
    else if (atn_age != 8'hff) atn_age <= atn_age + 8'h01;
    // Target has answered the current ATN once it showed MESSAGE OUT
    if (srst || (atn && !atn_q)) atn_served <= 1'b0;
    else if (msg_out) atn_served <= 1'b1;
  end
  sequence ext_rst_s;
    rst_oe_i && !rst_oe_t;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  sel_bsy_setup_a: assert property ($fell(bsy_i) && atn |-> atn_age >= DESKEW2 - 1)
    else $error("atn raised too late before busy release");
  qas_id_setup_a: assert property ($rose(sel_id) && atn |-> atn_age >= DESKEW2 - 1)
    else $error("atn raised too late before target id");
  ack_neg_setup_a: assert property ($fell(ack) && atn |-> atn_age >= ATN_SETUP - 1)
    else $error("atn setup before ack negation too short");
  retry_setup_a: assert property ($rose(ack) && atn && msg_out |-> atn_age >= DESKEW2 - 1)
    else $error("atn retry too late before ack");
  clear_setup_a: assert property ($rose(ack) && !atn |-> atn_age >= DESKEW2 - 1)
    else $error("atn cleared too late before ack");
  atn_ack_hold_a: assert property (msg_out && ack && $past(ack) |-> $stable(atn))
    else $error("atn changed while ack held in message out");
  atn_until_resp_a: assert property ($fell(atn) && !rst && !$past(rst)
    |-> msg_out || atn_served)
    else $error("atn dropped before message out");
  rst_bus_free_a: assert property (ext_rst_s ##1 rst_oe_i
    |-> phase == sarh_pkg::SARH_PH_FREE && !req)
    else $error("target held bus during reset");
  init_release_a: assert property ($rose(rst_oe_i)
    |-> ##[0:CLEAR_MAX] (!atn && !ack && !bsy_i && !sel_id))
    else $error("initiator kept bus signals after reset");
  no_rst_echo_a: assert property (ext_rst_s |-> ##1 !rst_oe_t [*8])
    else $error("target echoed reset");
endmodule
`default_nettype wire

// ### scsi_attention_and_reset_handler_tb.sv
// Self-checking bench joining initiator and target ends through the bus.
// Assumes a 200 MHz clock; all inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module scsi_attention_and_reset_handler_tb;
  localparam int RST_DELAY = sarh_pkg::RST_DELAY_CYC;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic usr_step = 1'b0, usr_boundary = 1'b0, usr_last_byte = 1'b0;
  logic usr_target_reset = 1'b0, lvd_mode = 1'b1, ua_clear = 1'b0;
  logic usr_attn = 1'b0, usr_select = 1'b0, usr_reset = 1'b0;
  sarh_pkg::sarh_phase_t usr_phase = sarh_pkg::SARH_PH_FREE;
  logic attn_pending, bus_released, hard_reset, default_agreement, msg_protocol_err;
  logic [2:0] ua_code;
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  sarh_bus_if bus (.ref_clk(ref_clk));
  // Short reset hold keeps the run brief; still above the reset delay
  sarh_target i_sarh_target (.ref_clk(ref_clk), .srst(srst), .bus(bus), .iu_enabled(1'b0),
    .usr_step(usr_step), .usr_phase(usr_phase), .usr_boundary(usr_boundary),
    .usr_last_byte(usr_last_byte), .usr_target_reset(usr_target_reset),
    .usr_assert_rst(1'b0), .lvd_mode(lvd_mode), .ua_clear(ua_clear),
    .attn_pending(attn_pending), .bus_released(bus_released), .hard_reset(hard_reset),
    .default_agreement(default_agreement), .ua_code(ua_code),
    .msg_protocol_err(msg_protocol_err));
  sarh_initiator #(.RST_HOLD(50)) i_sarh_initiator (.ref_clk(ref_clk), .srst(srst),
    .bus(bus), .usr_attn(usr_attn), .usr_more(1'b0), .usr_qas(1'b0),
    .usr_select(usr_select), .usr_reset(usr_reset), .busy(), .atn_out(), .rst_active());
  sarh_bus_properties i_sarh_bus_properties (.ref_clk(ref_clk), .srst(srst),
    .atn(bus.atn), .ack(bus.ack), .bsy_i(bus.bsy_i), .sel_id(bus.sel_id), .req(bus.req),
    .phase(bus.phase), .rst_oe_i(bus.rst_oe_i), .rst_oe_t(bus.rst_oe_t), .rst(bus.rst));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input sarh_pkg::sarh_phase_t ph);
    usr_phase = ph;
    usr_step = 1'b1;
    @(negedge ref_clk) usr_step = 1'b0;
    @(negedge ref_clk);
  endtask
  // Pulse inputs go back low after one cycle; level inputs just toggle
  task automatic pulse_ev(ref logic sig, input logic pulse, input logic [2:0] code);
    logic seen;
    seen = 1'b0;
    sig = ~sig;
    repeat (3) @(negedge ref_clk) begin
      if (pulse) sig = 1'b0;
      seen |= (hard_reset === 1'b1);
    end
    chk(seen && ua_code === code, "event or sense code");
    ua_clear = 1'b1;
    @(negedge ref_clk) ua_clear = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One attention per phase except reselection; each must wait for its yield point
  task automatic t_attention(input sarh_pkg::sarh_phase_t ph, input logic sel);
    step(ph);
    usr_attn = 1'b1;
    if (sel) usr_select = 1'b1;
    @(negedge ref_clk) usr_select = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk(attn_pending === 1'b1 && bus.atn === 1'b1, "attention not latched");
    chk(bus.phase === ph, "phase left before yield point");
    if (ph == sarh_pkg::SARH_PH_DATA) usr_boundary = 1'b1;
    else step(sarh_pkg::SARH_PH_STATUS);
    @(negedge ref_clk) usr_boundary = 1'b0;
    chk(bus.phase === sarh_pkg::SARH_PH_MSG_OUT, "no message out");
    usr_attn = 1'b0;
    // One more byte handshake lets ACK fall so ATN may drop
    step(sarh_pkg::SARH_PH_MSG_OUT);
    repeat (40) @(negedge ref_clk);
    chk(bus.atn === 1'b0 && attn_pending === 1'b0, "attention not cleared");
  endtask
  // Last byte sent with attention still set ends in bus free
  task automatic t_last_byte;
    logic err;
    err = 1'b0;
    step(sarh_pkg::SARH_PH_COMMAND);
    usr_attn = 1'b1;
    repeat (30) @(negedge ref_clk);
    step(sarh_pkg::SARH_PH_DATA);
    usr_last_byte = 1'b1;
    usr_phase = sarh_pkg::SARH_PH_MSG_OUT;
    usr_step = 1'b1;
    repeat (20) @(negedge ref_clk) begin
      usr_step = 1'b0;
      err |= (msg_protocol_err === 1'b1);
    end
    chk(err && bus.phase === sarh_pkg::SARH_PH_FREE, "late atn not caught");
    usr_last_byte = 1'b0;
    usr_attn = 1'b0;
    repeat (30) @(negedge ref_clk);
  endtask
  // Reset event must not come before the reset delay has run out
  task automatic t_bus_reset;
    int n;
    logic agr;
    agr = 1'b0;
    step(sarh_pkg::SARH_PH_DATA);
    usr_reset = 1'b1;
    @(negedge ref_clk) usr_reset = 1'b0;
    @(negedge ref_clk);
    chk(bus_released === 1'b1 && bus.phase === sarh_pkg::SARH_PH_FREE, "no release");
    for (n = 2; n < 80 && hard_reset !== 1'b1; n++) @(negedge ref_clk) agr |= default_agreement;
    chk(n >= RST_DELAY && n < 60 && ua_code === sarh_pkg::UA_BUS_RESET, "reset event");
    repeat (3) @(negedge ref_clk) agr |= (default_agreement === 1'b1);
    chk(agr && bus.rst_oe_t === 1'b0, "agreement or echo");
    repeat (60) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk(ua_code === sarh_pkg::UA_POWER_ON, "power on sense code");
    ua_clear = 1'b1;
    @(negedge ref_clk) ua_clear = 1'b0;
    chk(ua_code === sarh_pkg::UA_NONE, "sense code not cleared");
    t_attention(sarh_pkg::SARH_PH_SELECT, 1'b1);
    t_attention(sarh_pkg::SARH_PH_COMMAND, 1'b0);
    t_attention(sarh_pkg::SARH_PH_DATA, 1'b0);
    t_attention(sarh_pkg::SARH_PH_STATUS, 1'b0);
    t_attention(sarh_pkg::SARH_PH_MSG_IN, 1'b0);
    t_last_byte();
    t_bus_reset();
    pulse_ev(usr_target_reset, 1'b1, sarh_pkg::UA_TARGET_RESET);
    pulse_ev(lvd_mode, 1'b0, sarh_pkg::UA_MODE_SE);
    pulse_ev(lvd_mode, 1'b0, sarh_pkg::UA_MODE_LVD);
    results();
  end
endmodule
`default_nettype wire
